// *** hw/bnv_pkg.sv ***
// Purpose: Shared constants and types for the byte store access block
// Assumes: APB data 32 bits, register byte address is four times the index
// Notes:   Tick counts refer to the calibrated oscillator, not to pclk
package bnv_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL = 8'h1C;
  localparam logic [7:0] IDX_DATA = 8'h1D;
  localparam logic [7:0] IDX_ADDR_LO = 8'h1E;
  localparam logic [7:0] IDX_ADDR_HI = 8'h1F;
  localparam logic [7:0] IDX_STAT = 8'h20;
  localparam logic [7:0] IDX_CLR = 8'h21;
  localparam logic [7:0] IDX_IEN = 8'h22;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int BIT_READ_GO = 0;
  localparam int BIT_PROG_GO = 1;
  localparam int BIT_ARM = 2;
  localparam int BIT_RIE = 3;
  localparam int POS_MODE = 4;

  // Status bit positions
  localparam int EV_PROG_DONE = 0;
  localparam int EV_READ_DONE = 1;
  localparam int NUM_EV = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [2:0] READ_STALL = 3'h4;
  localparam logic [2:0] PROG_STALL = 3'h2;
  localparam int TIME_ATOMIC_US = 3400;
  localparam int TIME_SPLIT_US = 1800;
  localparam int OSC_KHZ = 8000;
  localparam int TICKS_ATOMIC = TIME_ATOMIC_US * OSC_KHZ / 1000;
  localparam int TICKS_SPLIT = TIME_SPLIT_US * OSC_KHZ / 1000;

  // Reset and erased values
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  typedef enum logic [1:0] {
    BNV_MODE_ATOMIC,
    BNV_MODE_ERASE,
    BNV_MODE_WRITE,
    BNV_MODE_RSVD
  } bnv_mode_t;

  // Programming job latched at start
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] data;
    bnv_mode_t mode;
  } bnv_job_t;

endpackage : bnv_pkg

// *** hw/bnv_store.sv ***
// Purpose: APB access controller for a byte-wide non-volatile data store
// Assumes: osc_clk is the calibrated oscillator, asynchronous to pclk
// Notes:   por_n keeps a running program alive across presetn
module bnv_store #(
  parameter int DEPTH = 512,
  parameter int PROG_ATOMIC_TICKS = bnv_pkg::TICKS_ATOMIC,
  parameter int PROG_SPLIT_TICKS = bnv_pkg::TICKS_SPLIT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_clk,
  input wire logic global_irq_enable,
  output logic nv_ready_irq,
  output logic irq
);

  localparam logic [8:0] ADDR_MASK = 9'(DEPTH - 1);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a[11:2] == {2'h0, idx}) && (a[1:0] == 2'h0);
  endfunction : hit

  logic [7:0] mem [DEPTH];
  logic [8:0] nv_byte_address;
  logic [7:0] nv_byte_data;
  bnv_pkg::bnv_mode_t nv_program_mode;
  logic nv_ready_irq_enable;
  logic [2:0] arm_cnt;
  logic arm_on;
  logic busy;
  bnv_pkg::bnv_job_t job;
  logic [19:0] tick_cnt;
  logic [bnv_pkg::NUM_EV-1:0] stat;
  logic [bnv_pkg::NUM_EV-1:0] ien;
  logic st_on;
  logic [2:0] st_cnt;
  logic pend_rd;
  logic pend_pg;
  logic osc_s1, osc_s2, osc_s3, osc_lvl;
  logic osc_tick;
  logic prog_done;
  logic access, take, mapped, ctrl_wr;
  logic trig_rd, trig_pg;
  logic [8:0] eff_addr;

  assign access = psel && penable;
  assign take = access && pready;
  assign mapped = hit(paddr, bnv_pkg::IDX_CTRL) || hit(paddr, bnv_pkg::IDX_DATA)
    || hit(paddr, bnv_pkg::IDX_ADDR_LO) || hit(paddr, bnv_pkg::IDX_ADDR_HI)
    || hit(paddr, bnv_pkg::IDX_STAT) || hit(paddr, bnv_pkg::IDX_CLR)
    || hit(paddr, bnv_pkg::IDX_IEN);
  assign ctrl_wr = access && pwrite && hit(paddr, bnv_pkg::IDX_CTRL);
  assign arm_on = (arm_cnt != 3'h0);
  assign eff_addr = nv_byte_address & ADDR_MASK;

  // Triggers judged on the first access cycle of a control write
  assign trig_rd = ctrl_wr && !st_on && pwdata[bnv_pkg::BIT_READ_GO] && !busy;
  assign trig_pg = ctrl_wr && !st_on && pwdata[bnv_pkg::BIT_PROG_GO] && arm_on && !busy
    && (nv_program_mode != bnv_pkg::BNV_MODE_RSVD);

  // Wait states hold the processor; a read outranks a program in the same write
  always_comb
  begin
    if (!access)
      pready = 1'b1;
    else if (st_on)
      pready = (st_cnt == 3'h0);
    else
      pready = !(trig_rd || trig_pg);
  end

  assign pslverr = access && !mapped;

  // ----------------------------------------------------------------
  // Stall sequencer
  // ----------------------------------------------------------------
  // Stall counter: cycles of wait state still owed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_on <= 1'b0;
      st_cnt <= 3'h0;
      pend_rd <= 1'b0;
      pend_pg <= 1'b0;
    end
    else if (take)
    begin
      st_on <= 1'b0;
      pend_rd <= 1'b0;
      pend_pg <= 1'b0;
    end
    else if (!st_on && (trig_rd || trig_pg))
    begin
      st_on <= 1'b1;
      pend_rd <= trig_rd;
      pend_pg <= trig_pg && !trig_rd;
      st_cnt <= trig_rd ? bnv_pkg::READ_STALL - 3'h1 : bnv_pkg::PROG_STALL - 3'h1;
    end
    else if (st_cnt != 3'h0)
      st_cnt <= st_cnt - 3'h1;
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Address and data; data also takes the byte fetched by a read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nv_byte_address <= 9'h000;
      nv_byte_data <= bnv_pkg::DATA_RESET;
    end
    else if (take && pwrite)
    begin
      if (hit(paddr, bnv_pkg::IDX_ADDR_LO))
        nv_byte_address[7:0] <= pwdata[7:0];
      if (hit(paddr, bnv_pkg::IDX_ADDR_HI))
        nv_byte_address[8] <= pwdata[0];
      if (hit(paddr, bnv_pkg::IDX_DATA))
        nv_byte_data <= pwdata[7:0];
      if (pend_rd)
        nv_byte_data <= mem[eff_addr];
    end
  end

  // Arm window: four cycles from the write that sets it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      arm_cnt <= 3'h0;
    else if (take && pend_pg)
      arm_cnt <= 3'h0;
    else if (take && ctrl_wr && pwdata[bnv_pkg::BIT_ARM])
      arm_cnt <= bnv_pkg::ARM_CYCLES;
    else if (arm_on)
      arm_cnt <= arm_cnt - 3'h1;
  end

  // Ready interrupt enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      nv_ready_irq_enable <= 1'b0;
    else if (take && ctrl_wr)
      nv_ready_irq_enable <= pwdata[bnv_pkg::BIT_RIE];
  end

  // Mode lives on por_n so that presetn cannot disturb a running program
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
      nv_program_mode <= bnv_pkg::BNV_MODE_ATOMIC;
    else if (!presetn && !busy)
      nv_program_mode <= bnv_pkg::BNV_MODE_ATOMIC;
    else if (presetn && take && ctrl_wr && !busy && !pend_pg)
      nv_program_mode <= bnv_pkg::bnv_mode_t'(pwdata[bnv_pkg::POS_MODE+:2]);
  end

  // ----------------------------------------------------------------
  // Oscillator tick detection
  // ----------------------------------------------------------------
  // Three stages; a rising edge counts once stages two and three agree
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      osc_lvl <= 1'b0;
    end
    else
    begin
      osc_s1 <= osc_clk;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      if (osc_s2 == osc_s3)
        osc_lvl <= osc_s3;
    end
  end

  assign osc_tick = (osc_s2 == osc_s3) && osc_s3 && !osc_lvl;

  // ----------------------------------------------------------------
  // Programming engine
  // ----------------------------------------------------------------
  assign prog_done = busy && osc_tick && (tick_cnt == 20'h00001);

  // Busy and duration count; counted in oscillator ticks only
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      busy <= 1'b0;
      tick_cnt <= 20'h00000;
      job <= '0;
    end
    else if (!busy && presetn && take && pend_pg)
    begin
      busy <= 1'b1;
      job.addr <= eff_addr;
      job.data <= nv_byte_data;
      job.mode <= nv_program_mode;
      if (nv_program_mode == bnv_pkg::BNV_MODE_ATOMIC)
        tick_cnt <= 20'(PROG_ATOMIC_TICKS);
      else
        tick_cnt <= 20'(PROG_SPLIT_TICKS);
    end
    else if (busy && osc_tick)
    begin
      tick_cnt <= tick_cnt - 20'h00001;
      if (tick_cnt == 20'h00001)
        busy <= 1'b0;
    end
  end

  // Cell update at the end of the programming time
  always_ff @(posedge pclk)
  begin
    if (prog_done)
    begin
      unique case (job.mode)
        bnv_pkg::BNV_MODE_ATOMIC: mem[job.addr] <= job.data;
        bnv_pkg::BNV_MODE_ERASE: mem[job.addr] <= bnv_pkg::ERASED_BYTE;
        bnv_pkg::BNV_MODE_WRITE: mem[job.addr] <= mem[job.addr] & job.data;
        bnv_pkg::BNV_MODE_RSVD: mem[job.addr] <= mem[job.addr];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat <= '0;
      ien <= '0;
    end
    else
    begin
      for (int i = 0; i < bnv_pkg::NUM_EV; i++)
      begin
        if (take && pwrite && hit(paddr, bnv_pkg::IDX_CLR) && pwdata[i])
          stat[i] <= 1'b0;
      end
      if (prog_done)
        stat[bnv_pkg::EV_PROG_DONE] <= 1'b1;
      if (take && pend_rd)
        stat[bnv_pkg::EV_READ_DONE] <= 1'b1;
      if (take && pwrite && hit(paddr, bnv_pkg::IDX_IEN))
        ien <= pwdata[bnv_pkg::NUM_EV-1:0];
    end
  end

  assign irq = |(stat & ien);
  assign nv_ready_irq = nv_ready_irq_enable && global_irq_enable && !busy;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= 32'h00000000;
      if (hit(paddr, bnv_pkg::IDX_CTRL))
        prdata[7:0] <= {2'h0, 2'(nv_program_mode), nv_ready_irq_enable, arm_on, busy, 1'b0};
      if (hit(paddr, bnv_pkg::IDX_DATA))
        prdata[7:0] <= nv_byte_data;
      if (hit(paddr, bnv_pkg::IDX_ADDR_LO))
        prdata[7:0] <= eff_addr[7:0];
      if (hit(paddr, bnv_pkg::IDX_ADDR_HI))
        prdata[0] <= eff_addr[8];
      if (hit(paddr, bnv_pkg::IDX_STAT))
        prdata[bnv_pkg::NUM_EV-1:0] <= stat;
      if (hit(paddr, bnv_pkg::IDX_IEN))
        prdata[bnv_pkg::NUM_EV-1:0] <= ien;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  read_stall_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(st_on) && pend_rd |-> (!pready) [*3] ##1 pready)
    else $error("read stall length wrong");

  prog_stall_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(st_on) && pend_pg |-> !pready ##1 pready)
    else $error("program stall length wrong");

  arm_expire_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(arm_on) && !ctrl_wr |-> arm_on [*4] ##1 (!arm_on || ctrl_wr))
    else $error("arm window not four cycles");

  go_unarmed_a: assert property (
    @(posedge pclk) disable iff (!presetn || !por_n)
    take && ctrl_wr && !pend_pg && !busy |=> !busy)
    else $error("program started without arm");

  prog_start_a: assert property (
    @(posedge pclk) disable iff (!presetn || !por_n)
    take && pend_pg |=> busy)
    else $error("armed go did not start program");

  busy_hold_a: assert property (
    @(posedge pclk) disable iff (!por_n)
    $rose(busy) |-> busy [*8])
    else $error("program ended too soon");

  mode_freeze_a: assert property (
    @(posedge pclk) disable iff (!por_n)
    busy && $past(busy) |-> $stable(nv_program_mode))
    else $error("mode changed while busy");

  read_block_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    busy |-> !st_on && !pend_rd && !pend_pg)
    else $error("access triggered while busy");

  read_load_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    take && pend_rd |=> nv_byte_data == $past(mem[eff_addr]))
    else $error("read data not loaded");

  erase_value_a: assert property (
    @(posedge pclk) disable iff (!por_n)
    prog_done && job.mode == bnv_pkg::BNV_MODE_ERASE |=> mem[$past(job.addr)] == bnv_pkg::ERASED_BYTE)
    else $error("erase left byte not blank");

  ready_irq_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(busy) |-> !nv_ready_irq ##1 !nv_ready_irq)
    else $error("ready interrupt while busy");

endmodule : bnv_store

// *** bench/bnv_osc_model.sv ***
// Purpose: Calibrated oscillator source beside the store controller
// Assumes: Period at least four pclk periods
// Notes:   Runs free, unrelated in phase to pclk
module bnv_osc_model #(
  parameter int HALF = 31
) (
  output logic osc_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  // Free running; odd start offset, yet some toggles still land on pclk edges
  initial
  begin
    osc_clk = 1'b0;
    #7;
    forever #(HALF) osc_clk = ~osc_clk;
  end
endmodule : bnv_osc_model

// *** bench/testbench.sv ***
// Purpose: Self-checking bench for the byte store access block
// Assumes: Short program tick counts, oscillator period 62 ns
// Notes:   One idle cycle after every APB transfer
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int AT = 16;
  localparam int SP = 8;
  localparam logic [7:0] CT = bnv_pkg::IDX_CTRL;
  localparam logic [7:0] DT = bnv_pkg::IDX_DATA;
  localparam logic [7:0] ST = bnv_pkg::IDX_STAT;
  logic pclk, presetn, por_n, psel, penable, pwrite, global_irq_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, osc_clk, nv_ready_irq, irq, err, irq_s, nvr_s, rie;
  int bad_count, total_checks, ws, t0;
  int cyc = 0;

  bnv_osc_model osc (.osc_clk(osc_clk));
  bnv_store #(.DEPTH(512), .PROG_ATOMIC_TICKS(AT), .PROG_SPLIT_TICKS(SP)) uut (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_clk(osc_clk), .global_irq_enable(global_irq_enable),
    .nv_ready_irq(nv_ready_irq), .irq(irq));

  // ------------------------------------------------------------
  // Clock and cycle count
  // ------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("TB: checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; pready sampled at rising edges, request held to the edge that takes it
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    ws = 0;
    forever
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      ws++;
      if (ws > 40)
      begin
        chk("pready wait", 32'h0, 32'h1);
        stop_test();
      end
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    irq_s = irq;
    nvr_s = nv_ready_irq;
  endtask : apb

  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [31:0] b);
    return (32'(m) << bnv_pkg::POS_MODE) | b | (32'(rie) << bnv_pkg::BIT_RIE);
  endfunction : ctl

  task automatic wait_idle();
    for (int i = 0; i < 300; i++)
    begin
      apb(1'b0, CT, 32'h0);
      if (rd[bnv_pkg::BIT_PROG_GO] === 1'b0) return;
    end
    chk("busy wait", 32'h0, 32'h1);
    stop_test();
  endtask : wait_idle

  task automatic set_addr(input logic [8:0] a);
    apb(1'b1, bnv_pkg::IDX_ADDR_HI, {31'h0, a[8]});
    apb(1'b1, bnv_pkg::IDX_ADDR_LO, {24'h0, a[7:0]});
  endtask : set_addr

  // Guarded sequence: idle, mode, address, data, arm, go
  task automatic prog(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d, input logic [31:0] xw);
    wait_idle();
    apb(1'b1, CT, ctl(m, 32'h0));
    set_addr(a);
    apb(1'b1, DT, {24'h0, d});
    apb(1'b1, CT, ctl(m, 32'h1 << bnv_pkg::BIT_ARM));
    apb(1'b1, CT, ctl(m, 32'h1 << bnv_pkg::BIT_PROG_GO));
    chk("program stall", xw, ws);
    t0 = cyc;
  endtask : prog

  task automatic rd_byte(input logic [8:0] a, input logic [7:0] exp);
    wait_idle();
    set_addr(a);
    apb(1'b1, CT, ctl(2'h0, 32'h1));
    chk("read stall", 32'h4, ws);
    apb(1'b0, DT, 32'h0);
    chk("read byte", {24'h0, exp}, rd);
  endtask : rd_byte

  task automatic chk_time(input string what, input int t);
    wait_idle();
    chk(what, 32'h1, {31'h0, (cyc - t0) >= (t - 1) * 6 && (cyc - t0) <= t * 7 + 12});
  endtask : chk_time

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic s_basic();
    apb(1'b0, DT, 32'h0);
    chk("data reset", 32'h0, rd);
    chk("mapped no error", 32'h0, {31'h0, err});
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    prog(2'h0, 9'h1A5, 8'h3C, 32'h2);
    apb(1'b0, CT, 32'h0);
    chk("go reads busy", 32'h1, {31'h0, rd[bnv_pkg::BIT_PROG_GO]});
    chk_time("atomic time", AT);
    rd_byte(9'h1A5, 8'h3C);
    prog(2'h0, 9'h0A5, 8'hC3, 32'h2);
    rd_byte(9'h1A5, 8'h3C);
  endtask : s_basic

  task automatic s_split();
    prog(2'h1, 9'h005, 8'h00, 32'h2);
    apb(1'b1, CT, ctl(2'h2, 32'h1));
    chk("read while busy", 32'h0, ws);
    apb(1'b0, CT, 32'h0);
    chk("mode held", 32'h1, {30'h0, rd[5:4]});
    chk_time("split time", SP);
    rd_byte(9'h005, bnv_pkg::ERASED_BYTE);
    prog(2'h2, 9'h005, 8'h5A, 32'h2);
    chk_time("write time", SP);
    rd_byte(9'h005, 8'h5A);
  endtask : s_split

  // Go without arm, after the arm lapsed, and in the reserved mode
  task automatic s_refuse();
    apb(1'b1, CT, ctl(2'h0, 32'h1 << bnv_pkg::BIT_PROG_GO));
    chk("go unarmed", 32'h0, ws);
    apb(1'b1, CT, ctl(2'h0, 32'h1 << bnv_pkg::BIT_ARM));
    repeat (4) @(posedge pclk);
    apb(1'b1, CT, ctl(2'h0, 32'h1 << bnv_pkg::BIT_PROG_GO));
    chk("arm lapsed", 32'h0, ws);
    prog(2'h3, 9'h005, 8'h00, 32'h0);
    apb(1'b0, CT, 32'h0);
    chk("reserved idle", 32'h0, {31'h0, rd[bnv_pkg::BIT_PROG_GO]});
  endtask : s_refuse

  task automatic s_irq();
    apb(1'b1, bnv_pkg::IDX_CLR, 32'h3);
    apb(1'b1, bnv_pkg::IDX_IEN, 32'h1);
    chk("irq clear", 32'h0, {31'h0, irq_s});
    global_irq_enable <= 1'b1;
    rie = 1'b1;
    prog(2'h0, 9'h007, 8'h11, 32'h2);
    chk("ready irq busy", 32'h0, {31'h0, nvr_s});
    wait_idle();
    chk("ready irq idle", 32'h1, {31'h0, nvr_s});
    apb(1'b0, ST, 32'h0);
    chk("status done", 32'h1, rd);
    chk("irq set", 32'h1, {31'h0, irq_s});
    apb(1'b1, bnv_pkg::IDX_IEN, 32'h2);
    chk("irq masked", 32'h0, {31'h0, irq_s});
    apb(1'b1, bnv_pkg::IDX_IEN, 32'h1);
    apb(1'b1, bnv_pkg::IDX_CLR, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq_s});
    rie = 1'b0;
  endtask : s_irq

  // Bus reset in mid program keeps the program and its mode
  task automatic s_rst_busy();
    prog(2'h1, 9'h009, 8'h00, 32'h2);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, CT, 32'h0);
    chk("busy after reset", 32'h12, {26'h0, rd[5:4], 2'h0, rd[1:0]});
    rd_byte(9'h009, bnv_pkg::ERASED_BYTE);
  endtask : s_rst_busy

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {presetn, por_n, psel, penable, pwrite, global_irq_enable, rie} = 7'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge pclk);
    s_basic();
    s_split();
    s_refuse();
    s_irq();
    s_rst_busy();
    stop_test();
  end
endmodule : testbench
